// *** hw/irq_ctrl_defs.vh ***
// register offsets, bit positions and reset values of the interrupt enable and flag block
`ifndef IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_DEFS_VH
// byte offsets on the register bus
`define OFS_INTERRUPT_CONTROL 8'h00
`define OFS_PERIPH_ENABLE 8'h04
`define OFS_PERIPH_FLAGS 8'h08
`define OFS_EDGE_CONFIG 8'h0c
`define OFS_PORT_SNAPSHOT 8'h10
// interrupt control bit positions
`define BIT_GLOBAL_EN 7
`define BIT_PERIPH_MASTER_EN 6
`define BIT_TIMER_EN 5
`define BIT_EXT_EN 4
`define BIT_PORT_EN 3
`define BIT_TIMER_FLAG 2
`define BIT_EXT_FLAG 1
`define BIT_PORT_FLAG 0
// edge configuration bit position
`define BIT_EDGE_SELECT 0
// reset values
`define RST_CONTROL 8'h00
`define RST_PERIPH 8'h00
`define RST_EDGE 1'h1
`endif

// *** hw/pin_sync.v ***
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter WIDTH = 5
) (
	input wire CLK,
	input wire NRST,
	input wire [WIDTH-1:0] d,
	output wire [WIDTH-1:0] q
);
	// -----------------------------
	// two-stage capture
	// -----------------------------
	reg [WIDTH-1:0] meta_reg; // first stage, read only by second stage
	reg [WIDTH-1:0] sync_reg; // second stage, safe to use
	// shift pins through both stages
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end
	assign q = sync_reg;
endmodule // pin_sync

// *** hw/core_interrupt_enable_flags.v ***
// interrupt enable, flag and request logic of a small core, with an AHB-Lite register slave
//
// Contract
// - port pin change sets port-change flag
// - flags stay set until software clears
// - separate per-source peripheral enable register
// - peripheral master enable gates peripheral sources
// - flags set regardless of any enable
// - global enable gates every interrupt
// - edge select picks external pin edge
`timescale 1ns/1ps
`include "irq_ctrl_defs.vh"
module core_interrupt_enable_flags #(
	parameter NPERIPH = 8,
	parameter NPORT = 4
) (
	input wire CLK,
	input wire NRST,
	input wire HSEL,
	input wire [31:0] HADDR,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire [2:0] HSIZE,
	input wire [31:0] HWDATA,
	input wire HREADY,
	output reg [31:0] HRDATA,
	output wire HREADYOUT,
	output wire HRESP,
	input wire TIMER_OVERFLOW,
	input wire [NPERIPH-1:0] PERIPH_EVENT,
	input wire EXTERNAL_IRQ_PIN,
	input wire [NPORT-1:0] UPPER_PORT_PINS,
	output wire CORE_IRQ
);
	// -----------------------------
	// registers and state
	// -----------------------------
	reg [7:0] interrupt_control_reg; // enables in high bits, flags in low bits
	reg [7:0] interrupt_control_next;
	reg [NPERIPH-1:0] peripheral_enable_reg; // one enable per peripheral source
	reg [NPERIPH-1:0] periph_flag_reg; // sticky peripheral flags
	reg [NPERIPH-1:0] periph_flag_next;
	reg external_edge_select_reg; // 1 rising, 0 falling
	reg [NPORT-1:0] port_last_reg; // previous synchronised port state
	reg ext_last_reg; // previous synchronised external pin
	reg timer_last_reg; // previous timer overflow level
	reg wr_pend_reg; // write data phase pending
	reg [7:0] wr_addr_reg; // latched write offset
	wire [NPORT:0] pins_sync; // synchronised pins, port high, ext at bit 0
	wire ext_pin;
	wire [NPORT-1:0] port_pins;
	wire port_change;
	wire ext_edge;
	wire timer_event;
	wire addr_phase;
	wire [7:0] rd_addr;
	wire wr_ctrl;
	wire wr_pen;
	wire wr_pflg;
	wire wr_edge;
	wire core_term;
	wire periph_term;

	// -----------------------------
	// pin synchronisation
	// -----------------------------
	// external pin at bit 0, upper port pins above it
	pin_sync #(
		.WIDTH(NPORT + 1)
	) u_sync (
		.CLK(CLK),
		.NRST(NRST),
		.d({UPPER_PORT_PINS, EXTERNAL_IRQ_PIN}),
		.q(pins_sync)
	);
	assign ext_pin = pins_sync[0];
	assign port_pins = pins_sync[NPORT:1];

	// -----------------------------
	// event detection
	// -----------------------------
	// the last-level registers reset to the synchroniser's reset level, so a
	// pin held low through reset gives no false edge when reset lifts
	// remember last pin and timer levels
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			port_last_reg <= {NPORT{1'b0}};
			ext_last_reg <= 1'b0;
			timer_last_reg <= 1'b0;
		end else begin
			port_last_reg <= port_pins;
			ext_last_reg <= ext_pin;
			timer_last_reg <= TIMER_OVERFLOW;
		end
	end
	// any upper port pin changed state
	assign port_change = |(port_pins ^ port_last_reg);
	// chosen edge of the external pin
	assign ext_edge = external_edge_select_reg ? (ext_pin & ~ext_last_reg)
		: (~ext_pin & ext_last_reg);
	// rising edge of the timer overflow level
	assign timer_event = TIMER_OVERFLOW & ~timer_last_reg;

	// -----------------------------
	// bus slave
	// -----------------------------
	// zero wait states: a read is answered in the data phase straight after
	// its address phase, a write lands at the edge that ends its data phase;
	// transfer size is not decoded, every register is one whole word
	assign HREADYOUT = 1'b1; // zero wait states
	assign HRESP = 1'b0; // always okay
	assign addr_phase = HSEL & HREADY & HTRANS[1];
	assign rd_addr = HADDR[7:0];
	// latch write address phase for the following data phase
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= addr_phase & HWRITE;
			if (addr_phase) begin
				wr_addr_reg <= HADDR[7:0];
			end
		end
	end
	// one write strobe per writable register
	assign wr_ctrl = wr_pend_reg & (wr_addr_reg == `OFS_INTERRUPT_CONTROL);
	assign wr_pen = wr_pend_reg & (wr_addr_reg == `OFS_PERIPH_ENABLE);
	assign wr_pflg = wr_pend_reg & (wr_addr_reg == `OFS_PERIPH_FLAGS);
	assign wr_edge = wr_pend_reg & (wr_addr_reg == `OFS_EDGE_CONFIG);
	// read data registered in address phase, unmapped offsets read zero
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			HRDATA <= 32'h00000000;
		end else if (addr_phase & ~HWRITE) begin
			case (rd_addr)
				`OFS_INTERRUPT_CONTROL: begin
					HRDATA <= {24'h000000, interrupt_control_next};
				end
				`OFS_PERIPH_ENABLE: begin
					HRDATA <= {{(32 - NPERIPH){1'b0}}, peripheral_enable_reg};
				end
				`OFS_PERIPH_FLAGS: begin
					HRDATA <= {{(32 - NPERIPH){1'b0}}, periph_flag_next};
				end
				`OFS_EDGE_CONFIG: begin
					HRDATA <= {31'h00000000, external_edge_select_reg};
				end
				`OFS_PORT_SNAPSHOT: begin
					HRDATA <= {{(32 - NPORT - 1){1'b0}}, port_pins, ext_pin};
				end
				default: begin
					HRDATA <= 32'h00000000;
				end
			endcase
		end
	end

	// -----------------------------
	// control and flag update
	// -----------------------------
	// software writes the control and flag words as plain stored values, so a
	// zero clears a flag; a hardware event in the same cycle wins over a
	// clearing write, so no event is lost, and hardware never lowers a flag
	always @* begin
		interrupt_control_next = interrupt_control_reg;
		periph_flag_next = periph_flag_reg;
		if (wr_ctrl) begin
			// only software lowers a flag, by writing the new value
			interrupt_control_next = HWDATA[7:0];
		end
		if (wr_pflg) begin
			periph_flag_next = HWDATA[NPERIPH-1:0];
		end
		// events set flags whatever the enables hold
		if (port_change) begin
			interrupt_control_next[`BIT_PORT_FLAG] = 1'b1;
		end
		if (ext_edge) begin
			interrupt_control_next[`BIT_EXT_FLAG] = 1'b1;
		end
		if (timer_event) begin
			interrupt_control_next[`BIT_TIMER_FLAG] = 1'b1;
		end
		periph_flag_next = periph_flag_next | PERIPH_EVENT;
	end
	// store control, flags, enables and edge select
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			interrupt_control_reg <= `RST_CONTROL;
			periph_flag_reg <= {NPERIPH{1'b0}};
			peripheral_enable_reg <= {NPERIPH{1'b0}};
			external_edge_select_reg <= `RST_EDGE;
		end else begin
			interrupt_control_reg <= interrupt_control_next;
			periph_flag_reg <= periph_flag_next;
			if (wr_pen) begin
				peripheral_enable_reg <= HWDATA[NPERIPH-1:0];
			end
			if (wr_edge) begin
				external_edge_select_reg <= HWDATA[`BIT_EDGE_SELECT];
			end
		end
	end

	// -----------------------------
	// interrupt request
	// -----------------------------
	// the request is a pure function of stored bits, so it rises at the very edge
	// that stores the flag and falls as soon as a write clears the cause
	// core sources: enable and flag pairs
	assign core_term =
		(interrupt_control_reg[`BIT_TIMER_EN] & interrupt_control_reg[`BIT_TIMER_FLAG]) |
		(interrupt_control_reg[`BIT_EXT_EN] & interrupt_control_reg[`BIT_EXT_FLAG]) |
		(interrupt_control_reg[`BIT_PORT_EN] & interrupt_control_reg[`BIT_PORT_FLAG]);
	// peripheral sources pass only with the master enable
	assign periph_term = interrupt_control_reg[`BIT_PERIPH_MASTER_EN]
		& (|(peripheral_enable_reg & periph_flag_reg));
	// global enable gates everything
	assign CORE_IRQ = interrupt_control_reg[`BIT_GLOBAL_EN]
		& (core_term | periph_term);
endmodule // core_interrupt_enable_flags

// *** bench/irq_src_model.sv ***
// event source model standing in for the timer, peripherals and port pins
`timescale 1ns/1ps
module irq_src_model #(
	parameter NPERIPH = 8,
	parameter NPORT = 4
) (
	input wire CLK,
	output logic tmr_ovf,
	output logic [NPERIPH-1:0] periph_ev,
	output logic ext_pin,
	output logic [NPORT-1:0] port_pins
);
	initial begin
		tmr_ovf = 1'b0;
		periph_ev = '0;
		ext_pin = 1'b0;
		port_pins = '0;
	end
	// one-cycle timer and peripheral pulses, pin levels held afterwards
	task automatic set(input logic t, input logic [NPERIPH-1:0] p, input logic e,
		input logic [NPORT-1:0] u);
		tmr_ovf <= t;
		periph_ev <= p;
		ext_pin <= e;
		port_pins <= u;
		@(posedge CLK);
		tmr_ovf <= 1'b0;
		periph_ev <= '0;
	endtask
endmodule // irq_src_model

// *** bench/core_interrupt_enable_flags_sva.sv ***
// port-level checker of the interrupt enable and flag block
`timescale 1ns/1ps
`include "irq_ctrl_defs.vh"
module core_interrupt_enable_flags_sva #(
	parameter NPORT = 4
) (
	input wire CLK,
	input wire NRST,
	input wire HSEL,
	input wire [31:0] HADDR,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire [31:0] HWDATA,
	input wire HREADY,
	input wire [31:0] HRDATA,
	input wire HREADYOUT,
	input wire HRESP,
	input wire TIMER_OVERFLOW,
	input wire [NPORT-1:0] UPPER_PORT_PINS,
	input wire CORE_IRQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	logic wph;
	logic [7:0] aq;
	logic [7:0] ctl_q;
	wire rd_req = HSEL & HREADY & HTRANS[1] & ~HWRITE;
	// shadow of the control register as written by software
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			wph <= 1'b0;
			aq <= 8'h00;
			ctl_q <= 8'h00;
		end else begin
			wph <= HSEL & HREADY & HTRANS[1] & HWRITE;
			aq <= HADDR[7:0];
			if (wph && HREADY && aq == `OFS_INTERRUPT_CONTROL)
				ctl_q <= HWDATA[7:0];
		end
	end
	sequence s_rd_addr; rd_req; endsequence
	property p_bus; HREADYOUT && !HRESP; endproperty
	a_bus: assert property (p_bus) else $error("bus answer not ready okay");
	property p_hold; !rd_req |=> $stable(HRDATA); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_unmap; s_rd_addr ##0 (HADDR[7:0] > 8'h13) |=> HRDATA == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_gie; !ctl_q[7] |-> !CORE_IRQ; endproperty
	a_gie: assert property (p_gie) else $error("request without global enable");
	property p_peripheral_master_enable; !ctl_q[6] && ctl_q[5:3] == 3'h0 |-> !CORE_IRQ; endproperty
	a_peripheral_master_enable: assert property (p_peripheral_master_enable) else $error("request with no source gate");
	property p_pin; $changed(UPPER_PORT_PINS) && ctl_q[7] && ctl_q[3] |-> ##[1:6] CORE_IRQ;
	endproperty
	a_pin: assert property (p_pin) else $error("pin change gave no request");
	property p_sticky; CORE_IRQ && !wph |=> CORE_IRQ; endproperty
	a_sticky: assert property (p_sticky) else $error("request dropped without write");
	property p_tmr; ctl_q[7] && ctl_q[5] && $rose(TIMER_OVERFLOW) |-> ##[1:2] CORE_IRQ;
	endproperty
	a_tmr: assert property (p_tmr) else $error("timer overflow gave no request");
endmodule // core_interrupt_enable_flags_sva
bind core_interrupt_enable_flags core_interrupt_enable_flags_sva #(.NPORT(NPORT)) u_sva (
	.CLK(CLK),
	.NRST(NRST),
	.HSEL(HSEL),
	.HADDR(HADDR),
	.HTRANS(HTRANS),
	.HWRITE(HWRITE),
	.HWDATA(HWDATA),
	.HREADY(HREADY),
	.HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT),
	.HRESP(HRESP),
	.TIMER_OVERFLOW(TIMER_OVERFLOW),
	.UPPER_PORT_PINS(UPPER_PORT_PINS),
	.CORE_IRQ(CORE_IRQ)
);

// *** bench/core_interrupt_enable_flags_tb_top.sv ***
// register-level testbench of the interrupt enable and flag block
`timescale 1ns/1ps
module core_interrupt_enable_flags_tb_top;
	logic CLK = 1'b0, NRST = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
	logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
	logic [1:0] HTRANS = 2'h0;
	logic [2:0] HSIZE = 3'h0;
	wire [31:0] HRDATA;
	wire HREADYOUT, HRESP, CORE_IRQ, tmr, ext;
	wire [7:0] pev;
	wire [3:0] pins;
	int error_cnt = 0, checked = 0;
	initial forever #4 CLK = ~CLK;
	irq_src_model src (.CLK(CLK), .tmr_ovf(tmr), .periph_ev(pev), .ext_pin(ext), .port_pins(pins));
	core_interrupt_enable_flags dut (.CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TIMER_OVERFLOW(tmr),
		.PERIPH_EVENT(pev), .EXTERNAL_IRQ_PIN(ext), .UPPER_PORT_PINS(pins), .CORE_IRQ(CORE_IRQ));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// one single AHB transfer, address phase then data phase
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HSIZE <= 3'h2;
		HADDR <= {24'h0, a};
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		r = HRDATA;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask
	// look at the request level mid-cycle, then realign to a rising edge
	task automatic irq(input logic e);
		repeat (2) @(posedge CLK);
		@(negedge CLK);
		chk({31'h0, CORE_IRQ}, {31'h0, e});
		@(posedge CLK);
	endtask
	task automatic wt;
		repeat (6) @(posedge CLK);
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge CLK);
		error_cnt++;
		give_verdict();
	end
	initial begin
		repeat (16) @(posedge CLK);
		NRST <= 1'b1;
		@(posedge CLK);
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h0);
		rd(8'h0c, 32'h1);
		rd(8'h14, 32'h0);
		src.set(0, 0, 0, 4'h5);
		wt();
		rd(8'h00, 32'h01);
		rd(8'h00, 32'h01);
		irq(0);
		wr(8'h00, 0);
		rd(8'h00, 32'h0);
		src.set(0, 0, 1, 4'h5);
		wt();
		rd(8'h00, 32'h02);
		wr(8'h00, 0);
		src.set(0, 0, 0, 4'h5);
		wt();
		rd(8'h00, 32'h0);
		wr(8'h0c, 0);
		src.set(0, 0, 1, 4'h5);
		wt();
		rd(8'h00, 32'h0);
		src.set(0, 0, 0, 4'h5);
		wt();
		rd(8'h00, 32'h02);
		wr(8'h00, 0);
		src.set(1, 0, 0, 4'h5);
		wt();
		rd(8'h00, 32'h04);
		wr(8'h00, 32'h24);
		irq(0);
		wr(8'h00, 32'ha4);
		irq(1);
		wr(8'h00, 32'ha0);
		irq(0);
		src.set(1, 0, 0, 4'h5);
		irq(1);
		wr(8'h00, 0);
		wr(8'h00, 32'h88);
		src.set(0, 0, 0, 4'ha);
		wt();
		irq(1);
		wr(8'h00, 0);
		rd(8'h10, 32'h14);
		// external pin source, falling edge selected
		wr(8'h00, 32'h90);
		src.set(0, 0, 1, 4'ha);
		wt();
		irq(0);
		src.set(0, 0, 0, 4'ha);
		wt();
		irq(1);
		wr(8'h00, 0);
		src.set(0, 8'h08, 0, 4'ha);
		wt();
		rd(8'h08, 32'h08);
		wr(8'h04, 32'h08);
		rd(8'h04, 32'h08);
		wr(8'h00, 32'h80);
		irq(0);
		wr(8'h00, 32'hc0);
		irq(1);
		wr(8'h04, 0);
		irq(0);
		wr(8'h08, 0);
		rd(8'h08, 32'h0);
		// park the pins low, then a second reset in mid-run returns every register to its reset value
		src.set(0, 0, 0, 4'h0);
		wt();
		rd(8'h00, 32'hc1);
		NRST <= 1'b0;
		repeat (2) @(posedge CLK);
		NRST <= 1'b1;
		@(posedge CLK);
		rd(8'h00, 32'h0);
		rd(8'h0c, 32'h1);
		irq(0);
		give_verdict();
	end
endmodule // core_interrupt_enable_flags_tb_top
